// ==== pkg/serial_tx_pkg.sv ====
// package of constants and types for the flow-controlled serial transmitter
// Overview of operation
// - byte handshake flow control is allowed only up to 19200 baud
// - handshake go level is 1 when inverted, 0 when noninverted
// - with flow control each byte waits until the handshake pin shows go
// - transmit pin selector 0..16; chosen pin becomes and stays an output
// - selector 16 sends on the dedicated serial output pin
// - config word is 16 bits; low 13 bits plus 20 us give bit period
// - config bit 13: 0 is 8 data no parity, 1 is 7 data even parity
// - config bit 14: 0 noninverted, 1 inverted serial levels
// - config bit 15: 0 drives both levels, 1 drives one level only on pins 0..15; the dedicated output always drives both
// - pacing value inserts that many milliseconds between bytes
// - sends raw or repeated bytes, byte strings, decimal hex binary text
// - handshake selector 0..15; chosen pin becomes and stays an input
// - optional millisecond timeout aborts the wait for go and reports it
// - bit rates up to 50000 bits per second are supported
// - no receive buffer; new items still queue while a transfer runs
// - open drive on pins 0..15: inverted drives only high, noninverted only ground
// - dedicated output is always inverted; polarity still sets handshake
// - even parity makes the count of ones over data and parity even
package serial_tx_pkg;
  // ***************************************************************
  // timing
  // ***************************************************************
  localparam int CLK_PERIOD_NS = 10;
  localparam int US_NS = 1000;
  localparam int MS_US = 1000;
  localparam int US_PER_S = 1000000;
  localparam int CYC_PER_US = US_NS / CLK_PERIOD_NS;
  localparam int CYC_PER_MS = CYC_PER_US * MS_US;
  localparam int PERIOD_OFFSET_US = 20;
  localparam int FLOW_MAX_BAUD = 19200;
  localparam int FLOW_MIN_PERIOD_US = (US_PER_S + FLOW_MAX_BAUD - 1) / FLOW_MAX_BAUD;
  localparam int BIT_CYC_W = 20;
  localparam int MS_CYC_W = 17;
  // ***************************************************************
  // pins and frame
  // ***************************************************************
  localparam int GPIO_PINS = 16;
  localparam int PIN_SEL_W = 5;
  localparam int FLOW_SEL_W = 4;
  localparam logic [PIN_SEL_W-1:0] DEDICATED_SEL = 5'h10;
  localparam int FRAME_BITS = 10;
  localparam logic [3:0] LAST_BIT = 4'h9;
  localparam int FIFO_DEPTH = 16;
  // ***************************************************************
  // configuration word layout, msb first: drive, polarity, format, period
  // ***************************************************************
  localparam int CFG_PERIOD_W = 13;
  typedef struct packed {
    logic open_drive;
    logic inverted;
    logic seven_even;
    logic [CFG_PERIOD_W-1:0] period;
  } serial_cfg_s;
  // ***************************************************************
  // text conversion
  // ***************************************************************
  localparam logic [8:0] DEC_DIGITS = 9'h005;
  localparam logic [8:0] HEX_DIGITS = 9'h004;
  localparam logic [8:0] BIN_DIGITS = 9'h010;
  localparam logic [7:0] ASCII_ZERO = 8'h30;
  localparam logic [7:0] ASCII_HEX_BASE = 8'h37;
  localparam logic [15:0] DEC_POW [0:4] = '{16'h0001, 16'h000A, 16'h0064, 16'h03E8,
                                           16'h2710};
  typedef enum logic [1:0] {KIND_RAW, KIND_DEC, KIND_HEX, KIND_BIN} item_kind_e;
  // one entry of the transmit item list
  typedef struct packed {
    item_kind_e kind;
    logic last;
    logic [7:0] repeats;
    logic [15:0] value;
  } tx_item_s;
  localparam int ITEM_W = $bits(tx_item_s);
endpackage

// ==== rtl/item_fifo.sv ====
// synchronous fifo with valid and ready on both sides
`timescale 1ns/1ps
module item_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input wire logic i_clk, // system clock
  input wire logic i_sys_rst, // synchronous reset, active high
  input wire logic i_in_valid, // writer offers data
  input wire logic [WIDTH-1:0] i_in_data, // write data
  output logic o_in_ready, // space available
  output logic o_out_valid, // data available
  output logic [WIDTH-1:0] o_out_data, // head entry
  input wire logic i_out_ready // reader takes head
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [0:DEPTH-1];
  logic [AW:0] wr_reg;
  logic [AW:0] rd_reg;
  logic push_w;
  logic pop_w;

  // ***************************************************************
  // flags
  // ***************************************************************
  // extra pointer bit tells full from empty without a counter
  assign o_out_valid = wr_reg != rd_reg;
  assign o_in_ready = (wr_reg[AW-1:0] != rd_reg[AW-1:0]) || (wr_reg[AW] == rd_reg[AW]);
  assign push_w = i_in_valid && o_in_ready;
  assign pop_w = o_out_valid && i_out_ready;
  assign o_out_data = mem[rd_reg[AW-1:0]];

  // pointers
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      wr_reg <= '0;
      rd_reg <= '0;
    end else begin
      if (push_w) wr_reg <= wr_reg + 1'b1;
      if (pop_w) rd_reg <= rd_reg + 1'b1;
    end
  end

  // storage, no reset needed
  always_ff @(posedge i_clk) begin
    if (push_w) mem[wr_reg[AW-1:0]] <= i_in_data;
  end
endmodule

// ==== rtl/async_serial_tx_flow_ctrl.sv ====
// flow-controlled asynchronous serial transmitter with text formatting
`timescale 1ns/1ps
module async_serial_tx_flow_ctrl (
  input wire logic i_clk, // 100 MHz clock
  input wire logic i_sys_rst, // synchronous reset, active high
  input wire logic [15:0] i_cfg, // bit period, format, polarity, drive
  input wire logic [serial_tx_pkg::PIN_SEL_W-1:0] i_tx_pin_sel, // 0..16
  input wire logic i_flow_en, // use the handshake pin
  input wire logic [serial_tx_pkg::FLOW_SEL_W-1:0] i_flow_pin_sel, // 0..15
  input wire logic [15:0] i_pace_ms, // idle ms between bytes
  input wire logic i_timeout_en, // bound the wait for go
  input wire logic [15:0] i_timeout_ms, // wait bound in ms
  input wire logic i_item_valid, // item offered
  input wire serial_tx_pkg::tx_item_s i_item, // transmit item list entry
  output logic o_item_ready, // item queue has room
  input wire logic [15:0] i_gpio_in, // pin levels, asynchronous
  output logic [15:0] o_gpio_out, // pin output levels
  output logic [15:0] o_gpio_oe, // pin drive enables
  output logic o_dedicated_serial_out, // dedicated serial output level
  output logic o_dedicated_serial_oe, // dedicated serial output enable
  output logic o_busy, // transfer in progress or queued
  output logic o_waiting_go, // held off by the handshake pin
  output logic o_timeout, // one-cycle pulse on abort
  output logic o_flow_rate_err // flow asked above its rate limit
);
  import serial_tx_pkg::*;

  typedef enum logic [2:0] {S_IDLE, S_LOAD, S_WAIT_GO, S_SHIFT, S_PACE} tx_state_e;

  tx_state_e state_reg;
  tx_item_s item_reg;
  tx_item_s head_w;
  serial_cfg_s cfg_reg;
  serial_cfg_s cfg_in_w;
  logic head_valid_w;
  logic pop_w;
  logic flush_reg;
  logic [8:0] rem_reg;
  logic [PIN_SEL_W-1:0] tsel_reg;
  logic [PIN_SEL_W-1:0] tsel_w;
  logic [FLOW_SEL_W-1:0] fsel_reg;
  logic [FRAME_BITS-1:0] frame_reg;
  logic [3:0] bit_cnt_reg;
  logic [BIT_CYC_W-1:0] cyc_reg;
  logic [BIT_CYC_W-1:0] bit_cyc_w;
  logic [MS_CYC_W-1:0] ms_cyc_reg;
  logic [15:0] ms_cnt_reg;
  logic [GPIO_PINS:0] dir_reg;
  logic [GPIO_PINS:0] out_reg;
  logic [15:0] meta_reg;
  logic [15:0] sync_reg;
  logic timeout_reg;
  logic rate_err_reg;

  // ***************************************************************
  // item queue
  // ***************************************************************
  // the formatter stalls the queue while a byte is on the wire
  assign pop_w = head_valid_w && (state_reg == S_IDLE);

  item_fifo #(
    .WIDTH(ITEM_W),
    .DEPTH(FIFO_DEPTH)
  ) u_queue (
    .i_clk(i_clk),
    .i_sys_rst(i_sys_rst),
    .i_in_valid(i_item_valid),
    .i_in_data(i_item),
    .o_in_ready(o_item_ready),
    .o_out_valid(head_valid_w),
    .o_out_data(head_w),
    .i_out_ready(pop_w)
  );

  // ***************************************************************
  // byte formatter
  // ***************************************************************
  logic [8:0] idx9_w;
  logic [3:0] idx_w;
  logic [15:0] hex_sh_w;
  logic [3:0] nib_w;
  logic [15:0] dec_q_w;
  logic [3:0] dec_d_w;
  logic [7:0] byte_w;
  logic skip_w;
  logic parity_w;
  logic [FRAME_BITS-1:0] frame_w;
  logic [8:0] digits_w;

  // digits count down from the most significant one
  assign idx9_w = rem_reg - 9'h001;
  assign idx_w = idx9_w[3:0];
  assign hex_sh_w = item_reg.value >> {idx_w[1:0], 2'b00};
  assign nib_w = hex_sh_w[3:0];
  // a zero quotient means a leading zero, which decimal text leaves out
  assign dec_q_w = item_reg.value / DEC_POW[(idx_w > 4'h4) ? 3'h4 : idx_w[2:0]];
  assign dec_d_w = 4'(dec_q_w % 16'h000A);
  assign skip_w = (item_reg.kind == KIND_DEC) && (dec_q_w == 16'h0000)
                  && (idx_w != 4'h0);

  // text and raw byte selection
  always_comb begin
    unique case (item_reg.kind)
      KIND_RAW: byte_w = item_reg.value[7:0];
      KIND_DEC: byte_w = ASCII_ZERO + {4'h0, dec_d_w};
      KIND_HEX: byte_w = (nib_w < 4'hA) ? ASCII_ZERO + {4'h0, nib_w}
                                         : ASCII_HEX_BASE + {4'h0, nib_w};
      KIND_BIN: byte_w = ASCII_ZERO + {7'h00, item_reg.value[idx_w]};
    endcase
  end

  // number of byte slots an item steps through; raw bytes repeat
  always_comb begin
    unique case (head_w.kind)
      KIND_RAW: digits_w = {1'b0, head_w.repeats} + 9'h001;
      KIND_DEC: digits_w = DEC_DIGITS;
      KIND_HEX: digits_w = HEX_DIGITS;
      KIND_BIN: digits_w = BIN_DIGITS;
    endcase
  end

  // frame: start 0, data lsb first, parity in 7E only, stop 1; always ten bits
  assign cfg_in_w = i_cfg;
  assign parity_w = ^byte_w[6:0];
  assign frame_w = cfg_in_w.seven_even ? {1'b1, parity_w, byte_w[6:0], 1'b0}
                                       : {1'b1, byte_w, 1'b0};

  // ***************************************************************
  // timing
  // ***************************************************************
  logic [15:0] period_us_w;
  logic flow_ok_w;
  logic flow_now_w;
  logic bit_end_w;
  logic ms_wrap_w;
  logic timing_w;

  // field plus fixed offset; product fits 20 bits for the widest field
  assign bit_cyc_w = BIT_CYC_W'((32'(cfg_reg.period) + PERIOD_OFFSET_US) * CYC_PER_US);
  assign bit_end_w = cyc_reg == bit_cyc_w - 1'b1;
  assign period_us_w = 16'(32'(cfg_in_w.period) + PERIOD_OFFSET_US);
  assign flow_ok_w = 32'(period_us_w) >= FLOW_MIN_PERIOD_US;
  // handshake honoured only when asked for and the rate allows it
  assign flow_now_w = i_flow_en && flow_ok_w;
  assign ms_wrap_w = ms_cyc_reg == MS_CYC_W'(CYC_PER_MS - 1);
  assign timing_w = (state_reg == S_WAIT_GO) || (state_reg == S_PACE);

  // millisecond timer restarts on every entry to a waiting state
  always_ff @(posedge i_clk) begin
    if (i_sys_rst || !timing_w) begin
      ms_cyc_reg <= '0;
      ms_cnt_reg <= '0;
    end else if (ms_wrap_w) begin
      ms_cyc_reg <= '0;
      ms_cnt_reg <= ms_cnt_reg + 16'h0001;
    end else begin
      ms_cyc_reg <= ms_cyc_reg + 1'b1;
    end
  end

  // ***************************************************************
  // pin input synchroniser
  // ***************************************************************
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      meta_reg <= '0;
      sync_reg <= '0;
    end else begin
      meta_reg <= i_gpio_in;
      sync_reg <= meta_reg;
    end
  end

  // ***************************************************************
  // control
  // ***************************************************************
  logic go_w;
  logic pace_done_w;
  logic tmo_w;
  logic more_w;

  // go level follows polarity: 1 when inverted, 0 when not
  assign go_w = sync_reg[fsel_reg] == cfg_reg.inverted;
  assign tmo_w = i_timeout_en && (ms_cnt_reg == i_timeout_ms);
  assign pace_done_w = ms_cnt_reg == i_pace_ms;
  assign more_w = rem_reg != 9'h000;
  assign tsel_w = (i_tx_pin_sel > DEDICATED_SEL) ? DEDICATED_SEL : i_tx_pin_sel;

  // one byte at a time; no item is popped from the queue while a byte is sent
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      state_reg <= S_IDLE;
      item_reg <= '0;
      rem_reg <= '0;
      flush_reg <= 1'b0;
      timeout_reg <= 1'b0;
    end else begin
      timeout_reg <= 1'b0;
      unique case (state_reg)
        S_IDLE: begin
          if (pop_w && flush_reg) begin
            flush_reg <= !head_w.last; // drop the rest of an aborted list
          end else if (pop_w) begin
            item_reg <= head_w;
            rem_reg <= digits_w;
            state_reg <= S_LOAD;
          end
        end
        S_LOAD: begin
          rem_reg <= idx9_w;
          if (!skip_w) state_reg <= flow_now_w ? S_WAIT_GO : S_SHIFT;
        end
        S_WAIT_GO: begin
          if (go_w) begin
            state_reg <= S_SHIFT;
          end else if (tmo_w) begin
            timeout_reg <= 1'b1;
            flush_reg <= !item_reg.last;
            state_reg <= S_IDLE;
          end
        end
        S_SHIFT: begin
          if (bit_end_w && bit_cnt_reg == LAST_BIT) begin
            if (i_pace_ms != 16'h0000) state_reg <= S_PACE;
            else state_reg <= more_w ? S_LOAD : S_IDLE;
          end
        end
        S_PACE: begin
          if (pace_done_w) state_reg <= more_w ? S_LOAD : S_IDLE;
        end
      endcase
    end
  end

  // ***************************************************************
  // frame latch and shifter
  // ***************************************************************
  logic load_w;

  assign load_w = (state_reg == S_LOAD) && !skip_w;

  // settings are taken per byte so a frame never changes mid-flight
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      cfg_reg <= '0;
      tsel_reg <= '0;
      fsel_reg <= '0;
      rate_err_reg <= 1'b0;
      frame_reg <= '1;
    end else if (load_w) begin
      cfg_reg <= cfg_in_w;
      tsel_reg <= tsel_w;
      fsel_reg <= i_flow_pin_sel;
      rate_err_reg <= i_flow_en && !flow_ok_w;
      frame_reg <= frame_w;
    end else if (state_reg == S_SHIFT && bit_end_w) begin
      frame_reg <= {1'b1, frame_reg[FRAME_BITS-1:1]};
    end
  end

  // bit timer and bit counter run only while a frame is shifted out
  // so every frame starts from a clean count
  always_ff @(posedge i_clk) begin
    if (i_sys_rst || state_reg != S_SHIFT) begin
      cyc_reg <= '0;
      bit_cnt_reg <= '0;
    end else if (bit_end_w) begin
      cyc_reg <= '0;
      bit_cnt_reg <= bit_cnt_reg + 4'h1;
    end else begin
      cyc_reg <= cyc_reg + 1'b1;
    end
  end

  // ***************************************************************
  // pin direction and levels
  // ***************************************************************
  logic line_bit_w;
  logic pin_lvl_w;
  logic mark_lvl_w;

  assign line_bit_w = (state_reg == S_SHIFT) ? frame_reg[0] : 1'b1;
  // dedicated output ignores the polarity bit
  assign pin_lvl_w = (tsel_reg == DEDICATED_SEL) ? !line_bit_w
                     : line_bit_w ^ cfg_reg.inverted;
  assign mark_lvl_w = (tsel_w == DEDICATED_SEL) ? 1'b0 : !cfg_in_w.inverted;

  // chosen pins keep their direction after the transfer
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      dir_reg <= '0;
      out_reg <= '0;
    end else if (load_w) begin
      if (i_flow_en) dir_reg[i_flow_pin_sel] <= 1'b0;
      dir_reg[tsel_w] <= 1'b1;
      out_reg[tsel_w] <= mark_lvl_w;
    end else if (state_reg != S_IDLE && state_reg != S_LOAD) begin
      out_reg[tsel_reg] <= pin_lvl_w;
    end
  end

  // open drive enables only the active level
  genvar gi;
  generate
    for (gi = 0; gi < GPIO_PINS; gi++) begin : g_pin
      assign o_gpio_oe[gi] = dir_reg[gi]
                             && (!cfg_reg.open_drive || out_reg[gi] == cfg_reg.inverted);
      assign o_gpio_out[gi] = out_reg[gi];
    end
  endgenerate

  // ***************************************************************
  // outputs
  // ***************************************************************
  assign o_dedicated_serial_out = out_reg[GPIO_PINS];
  assign o_dedicated_serial_oe = dir_reg[GPIO_PINS];
  assign o_busy = (state_reg != S_IDLE) || head_valid_w;
  assign o_waiting_go = state_reg == S_WAIT_GO;
  assign o_timeout = timeout_reg;
  assign o_flow_rate_err = rate_err_reg;
endmodule

// ==== testbench/serial_tx_chk_sva.sv ====
// port-level assertion checker for the flow-controlled serial transmitter
`timescale 1ns/1ps
module serial_tx_chk (
  input wire logic i_clk, // clock
  input wire logic i_sys_rst, // synchronous reset
  input wire logic [15:0] i_cfg, // config word
  input wire logic [serial_tx_pkg::PIN_SEL_W-1:0] i_tx_pin_sel, // transmit pin
  input wire logic i_flow_en, // handshake in use
  input wire logic [serial_tx_pkg::FLOW_SEL_W-1:0] i_flow_pin_sel, // handshake pin
  input wire logic i_timeout_en, // wait bound on
  input wire logic [15:0] i_timeout_ms, // wait bound
  input wire logic i_item_valid, // item offered
  input wire logic o_item_ready, // queue room
  input wire logic [15:0] i_gpio_in, // pin levels
  input wire logic [15:0] o_gpio_out, // pin outputs
  input wire logic [15:0] o_gpio_oe, // pin enables
  input wire logic o_dedicated_serial_out, // dedicated level
  input wire logic o_dedicated_serial_oe, // dedicated enable
  input wire logic o_busy, // transfer pending
  input wire logic o_waiting_go, // held off
  input wire logic o_timeout, // abort pulse
  input wire logic o_flow_rate_err // rate error
);
  import serial_tx_pkg::*;
  // ********************
  // helper logic
  // ********************
  logic [3:0] stop_h; // last four handshake samples, 1 = stop level
  logic stop_now;
  int run; // cycles since the dedicated line last moved
  int bit_cyc;
  assign stop_now = i_gpio_in[i_flow_pin_sel] != i_cfg[14];
  assign bit_cyc = (int'(i_cfg[12:0]) + PERIOD_OFFSET_US) * CYC_PER_US;
  // history restarts mixed so neither all-stop nor all-go holds just after reset
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      stop_h <= 4'h5;
      run <= 0;
    end else begin
      stop_h <= {stop_h[2:0], stop_now};
      run <= $changed(o_dedicated_serial_out) ? 1 : run + 1;
    end
  end
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_sys_rst);
  // ********************
  // properties
  // ********************
  property p_tmo_pulse; o_timeout |=> !o_timeout; endproperty
  a_tmo_pulse: assert property (p_tmo_pulse) else $error("abort pulse too long");
  property p_tmo_zero; o_waiting_go && i_timeout_en && i_timeout_ms == 16'h0000 |-> ##[0:3] o_timeout; endproperty
  a_tmo_zero: assert property (p_tmo_zero) else $error("zero bound not aborted");
  property p_hold; o_waiting_go && (&stop_h) && !i_timeout_en |=> o_waiting_go; endproperty
  a_hold: assert property (p_hold) else $error("sent without go");
  property p_go; o_waiting_go && stop_h == 4'h0 |-> ##[0:2] !o_waiting_go; endproperty
  a_go: assert property (p_go) else $error("go ignored");
  property p_flow_in; o_waiting_go |-> !o_gpio_oe[i_flow_pin_sel]; endproperty
  a_flow_in: assert property (p_flow_in) else $error("handshake pin driven");
  property p_err_set;
    i_item_valid && o_item_ready && !o_busy && i_flow_en && i_cfg[12:0] < 13'h0021
      |-> ##[1:4] o_flow_rate_err;
  endproperty
  a_err_set: assert property (p_err_set) else $error("rate error missing");
  property p_err_cause; $rose(o_flow_rate_err) |-> i_flow_en && i_cfg[12:0] < 13'h0021; endproperty
  a_err_cause: assert property (p_err_cause) else $error("rate error without cause");
  property p_open;
    o_busy && i_cfg[15] && !i_tx_pin_sel[4] && o_gpio_oe[i_tx_pin_sel[3:0]]
      |-> o_gpio_out[i_tx_pin_sel[3:0]] == i_cfg[14];
  endproperty
  a_open: assert property (p_open) else $error("open drive on wrong level");
  property p_ded_idle; o_dedicated_serial_oe && !o_busy |-> !o_dedicated_serial_out; endproperty
  a_ded_idle: assert property (p_ded_idle) else $error("dedicated idle not low");
  property p_bit_len; o_busy && $changed(o_dedicated_serial_out) |-> run >= bit_cyc; endproperty
  a_bit_len: assert property (p_bit_len) else $error("bit shorter than period");
  c_tmo: cover property (o_timeout);
  c_go: cover property ($fell(o_waiting_go) && !o_timeout);
  c_err: cover property ($rose(o_flow_rate_err));
endmodule
bind async_serial_tx_flow_ctrl serial_tx_chk serial_tx_chk_i (
  .i_clk, .i_sys_rst, .i_cfg, .i_tx_pin_sel, .i_flow_en, .i_flow_pin_sel, .i_timeout_en,
  .i_timeout_ms, .i_item_valid, .o_item_ready, .i_gpio_in, .o_gpio_out, .o_gpio_oe,
  .o_dedicated_serial_out, .o_dedicated_serial_oe, .o_busy, .o_waiting_go, .o_timeout,
  .o_flow_rate_err
);

// ==== testbench/flow_partner.sv ====
// far-side serial node: grants send permission and decodes frames
`timescale 1ns/1ps
module flow_partner (
  input wire logic i_clk, // clock
  input wire logic i_line, // data line level
  input wire logic i_line_inv, // data line inverted
  input wire logic i_fc_inv, // handshake polarity
  input wire logic i_seven, // 7 data plus parity
  input wire logic i_ready, // node may accept a byte
  input wire logic [31:0] i_bit_cyc, // cycles per bit
  output logic o_fpin, // handshake level
  output logic [7:0] o_data, // last data
  output logic o_par, // last parity bit
  output logic o_stop, // last stop bit
  output int o_count // frames seen
);
  logic got; // byte taken, show stop until re-armed
  logic [8:0] bits;
  // go only while armed and before a byte arrives
  assign o_fpin = (i_ready && !got) ? i_fc_inv : !i_fc_inv;
  // sample mid-bit; a start edge seen a cycle late still lands well inside each bit
  initial begin
    got = 1'b0;
    o_count = 0;
    forever begin
      @(posedge i_clk);
      if (!i_ready) got = 1'b0;
      if (!(i_line ^ i_line_inv)) begin
        repeat (i_bit_cyc / 2) @(posedge i_clk);
        for (int b = 0; b < 9; b++) begin
          repeat (i_bit_cyc) @(posedge i_clk);
          bits[b] = i_line ^ i_line_inv;
        end
        o_data = i_seven ? {1'b0, bits[6:0]} : bits[7:0];
        o_par = i_seven & bits[7];
        o_stop = i_seven ? bits[8] : bits[8];
        got = 1'b1;
        o_count++;
      end
    end
  end
endmodule

// ==== testbench/tb.sv ====
// self-checking bench for the flow-controlled serial transmitter
`timescale 1ns/1ps
module tb;
  import serial_tx_pkg::*;
  logic i_clk, i_sys_rst, flow_en, tmo_en, valid, ready_rx, line, fpin, par, stop;
  logic item_ready, ded_out, ded_oe, busy, waiting, tmo, rate_err;
  serial_cfg_s cfg;
  logic [4:0] tsel;
  logic [3:0] fsel;
  logic [7:0] rx_data;
  logic [15:0] pins, gpio_out, gpio_oe;
  tx_item_s item;
  int rx_count, bit_cyc, num_errors, checks_done, acc, c0;
  int exp_q[$];
  async_serial_tx_flow_ctrl async_serial_tx_flow_ctrl_i (
    .i_clk, .i_sys_rst, .i_cfg(cfg), .i_tx_pin_sel(tsel), .i_flow_en(flow_en),
    .i_flow_pin_sel(fsel), .i_pace_ms(16'h0000), .i_timeout_en(tmo_en),
    .i_timeout_ms(16'h0000), .i_item_valid(valid), .i_item(item), .o_item_ready(item_ready),
    .i_gpio_in(pins), .o_gpio_out(gpio_out), .o_gpio_oe(gpio_oe),
    .o_dedicated_serial_out(ded_out), .o_dedicated_serial_oe(ded_oe), .o_busy(busy),
    .o_waiting_go(waiting), .o_timeout(tmo), .o_flow_rate_err(rate_err));
  flow_partner flow_partner_i (
    .i_clk, .i_line(line), .i_line_inv(tsel[4] | cfg.inverted), .i_fc_inv(cfg.inverted),
    .i_seven(cfg.seven_even), .i_ready(ready_rx), .i_bit_cyc(bit_cyc), .o_fpin(fpin),
    .o_data(rx_data), .o_par(par), .o_stop(stop), .o_count(rx_count));
  // released pins fall to the idle level; the handshake pin is the partner's
  always_comb begin
    for (int k = 0; k < 16; k++) pins[k] = gpio_oe[k] ? gpio_out[k] : !cfg.inverted;
    pins[fsel] = fpin;
  end
  assign line = tsel[4] ? (ded_oe & ded_out) : pins[tsel[3:0]];
  assign bit_cyc = (int'(cfg.period) + PERIOD_OFFSET_US) * CYC_PER_US;
  initial begin
    i_clk = 1'b0;
    forever #5 i_clk = ~i_clk;
  end
  // ********************
  // tasks
  // ********************
  task automatic check(string name, logic [31:0] seen, logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      num_errors++;
      $display("[FAIL] %s expected %0h seen %0h", name, exp, seen);
    end
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task automatic tick(int n);
    repeat (n) @(posedge i_clk);
    #1;
  endtask
  // every wait is bounded; running out ends the run
  task automatic wait_for(ref logic sig, input logic lvl, input int lim);
    int n;
    n = 0;
    while (sig !== lvl && n < lim) begin
      tick(1);
      n++;
    end
    if (sig !== lvl) begin
      check("wait_level", sig, lvl);
      final_report();
    end
  endtask
  task automatic send(tx_item_s it);
    item = it;
    valid = 1'b1;
    wait_for(item_ready, 1'b1, 100);
    tick(1);
    valid = 1'b0;
  endtask
  // reference: one character per item; decimal only for single digits here
  function automatic int model(tx_item_s it, logic seven);
    int ch;
    ch = (it.kind == KIND_DEC) ? int'(ASCII_ZERO) + int'(it.value) : int'(it.value[7:0]);
    if (seven) ch = ch & 32'h7F;
    if (seven && ^ch[6:0]) ch = ch | 32'h100;
    return ch;
  endfunction
  task automatic rx_check(int n0);
    int e;
    e = exp_q.pop_front();
    check("frames", rx_count, n0 + 1);
    check("data", rx_data, e[7:0]);
    check("parity", par, e[8]);
    check("stop_bit", stop, 1'b1);
  endtask
  // ********************
  // main sequence
  // ********************
  initial begin
    i_sys_rst = 1'b1;
    cfg = '0;
    tsel = 5'h00;
    fsel = 4'h1;
    flow_en = 1'b0;
    tmo_en = 1'b0;
    valid = 1'b0;
    ready_rx = 1'b0;
    item = '0;
    void'($urandom(91139));
    tick(4);
    i_sys_rst = 1'b0;
    check("oe_reset", gpio_oe, 16'h0000);
    check("busy_reset", busy, 1'b0);
    check("ready_reset", item_ready, 1'b1);
    $display("test reset done");
    // queue fills behind a stop level, then a zero bound discards it through last
    cfg = 16'h8021;
    tsel = 5'($urandom_range(0, 15));
    fsel = tsel[3:0] ^ 4'h1;
    flow_en = 1'b1;
    valid = 1'b1;
    acc = 0;
    repeat (20) begin
      item = '{KIND_RAW, acc == 16, 8'h00, 16'h00A5};
      if (item_ready === 1'b1) acc++;
      tick(1);
    end
    valid = 1'b0;
    check("accepted", acc, FIFO_DEPTH + 1);
    check("full", item_ready, 1'b0);
    check("waiting", waiting, 1'b1);
    check("flow_pin_oe", gpio_oe[fsel], 1'b0);
    c0 = rx_count;
    tmo_en = 1'b1;
    wait_for(tmo, 1'b1, 10);
    wait_for(busy, 1'b0, 100);
    check("frames_dropped", rx_count, c0);
    tmo_en = 1'b0;
    $display("test timeout done");
    // too fast for the handshake: it is ignored and flagged; open inverted pin
    cfg = 16'hC000;
    tsel = 5'($urandom_range(0, 15));
    fsel = tsel[3:0] ^ 4'h1;
    c0 = rx_count;
    item = '{KIND_RAW, 1'b1, 8'h00, 16'($urandom_range(0, 255))};
    exp_q.push_back(model(item, 1'b0));
    send(item);
    wait_for(busy, 1'b0, 30000);
    check("rate_err", rate_err, 1'b1);
    rx_check(c0);
    $display("test fast open done");
    // slow 7E noninverted on the dedicated line, grant held back a while
    cfg = 16'h2021;
    tsel = 5'h10;
    c0 = rx_count;
    item = '{KIND_DEC, 1'b1, 8'h00, 16'($urandom_range(0, 9))};
    exp_q.push_back(model(item, 1'b1));
    send(item);
    wait_for(waiting, 1'b1, 10);
    tick(300);
    check("still_waiting", waiting, 1'b1);
    ready_rx = 1'b1;
    wait_for(waiting, 1'b0, 10);
    wait_for(busy, 1'b0, 60000);
    check("rate_ok", rate_err, 1'b0);
    check("ded_oe", ded_oe, 1'b1);
    check("fpin_stop", fpin, 1'b1);
    rx_check(c0);
    $display("test flow dedicated done");
    final_report();
  end
endmodule
